/* File: cpc_top.sv */
// capture / auxiliary pwm unit with wishbone register slave
// assumes synchronous pin and sync inputs, one clock, async low reset
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cpc_top #(
  parameter int CW = 32 // counter width
) (
  input wire logic sys_clk_in, // 100 MHz functional clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write
  input wire logic [9:0] wb_adr_in, // wishbone byte address
  input wire logic [3:0] wb_sel_in, // wishbone byte lanes
  input wire logic [31:0] wb_dat_in, // wishbone write data
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  input wire logic emu_suspend_in, // debug suspend request
  input wire logic pin_in, // capture_pwm_pin input level
  output logic pin_out, // capture_pwm_pin driven level
  output logic pin_oe_out, // high while driving the pin
  input wire logic sync_input_in, // sync_input pulse from upstream
  output logic sync_output_out, // sync_output pulse to downstream
  output logic [7:0] event_out, // event pulses, bit 0 unused
  output logic int_req_out // enabled event pulse
);

  // ************************************************************
  // registers and state
  // ************************************************************
  cpc_pkg::cpc_ctl1_s ctl1_r; // capture_control_one
  cpc_pkg::cpc_ctl2_s ctl2_r; // capture_control_two
  logic [15:0] inten_r; // interrupt_enable
  logic [CW-1:0] counter_r; // time_stamp_counter
  logic [CW-1:0] phase_r; // phase_offset_value
  logic [CW-1:0] cap_r [4]; // capture_reg_one..four
  logic [1:0] index_r; // event_index_counter
  logic armed_r; // loads and index not frozen
  logic level_d_r; // previous divided pin level
  logic ack_r; // bus acknowledge
  logic [31:0] rdata_r; // bus read data
  logic pwm_r; // pwm output level
  logic sync_out_r; // sync output pulse
  logic [7:0] event_r; // registered event pulses
  logic int_r; // registered interrupt request

  // ************************************************************
  // combinational decode
  // ************************************************************
  logic level; // divided pin level
  logic bus_go; // bus access taken this edge
  logic [7:0] widx; // addressed register index
  logic wr; // write taken
  logic pwm_mode; // auxiliary_pwm_mode
  logic soft_sync; // soft_sync_force written as one
  logic rearm; // oneshot_rearm written as one
  logic sync_load; // phase load into counter
  logic halted; // counter held by run control or suspend
  logic cap_fire; // capture event at current index
  logic period_match; // period_match_event
  logic compare_match; // compare_match_event
  logic overflow; // counter_overflow_event

  // merge write data into a word by byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // edge select bit of capture event k (0..3)
  function automatic logic edge_of(input logic [7:0] ce,
      input logic [1:0] k);
    return ce[{k, 1'b0}];
  endfunction : edge_of

  // counter clear bit of capture event k (0..3)
  function automatic logic clear_of(input logic [7:0] ce,
      input logic [1:0] k);
    return ce[{k, 1'b1}];
  endfunction : clear_of

  assign bus_go = wb_cyc_in & wb_stb_in & ~ack_r;
  assign widx = wb_adr_in[cpc_pkg::ADR_LSB +: 8];
  assign wr = bus_go & wb_we_in;
  assign pwm_mode = ctl2_r.capture_or_pwm_select;
  assign soft_sync = wr & (widx == cpc_pkg::IDX_CTL2) & wb_sel_in[1]
      & wb_dat_in[8];
  assign rearm = wr & (widx == cpc_pkg::IDX_CTL2) & wb_sel_in[0]
      & wb_dat_in[3];
  assign sync_load = soft_sync
      | (ctl2_r.sync_in_enable & sync_input_in);

  // run control plus debug suspend handling
  always_comb begin
    halted = ~ctl2_r.counter_run_control;
    if (emu_suspend_in) begin
      unique case (ctl1_r.emu_halt_mode)
        cpc_pkg::EMU_STOP_NOW: halted = 1'b1;
        cpc_pkg::EMU_RUN_TO_ZERO: halted = halted | (counter_r == '0);
        default: halted = halted; // run free
      endcase
    end
  end

  // capture event on the edge chosen for the current index
  assign cap_fire = ~pwm_mode & armed_r & (edge_of(ctl1_r.clear_edge,
      index_r) ? (level_d_r & ~level) : (~level_d_r & level));
  assign period_match = pwm_mode & (counter_r == cap_r[0]);
  assign compare_match = pwm_mode & (counter_r == cap_r[1]);
  assign overflow = ~halted & (counter_r == cpc_pkg::COUNT_ALL_ONES);

  // ************************************************************
  // event prescaler
  // ************************************************************
  cpc_prescaler #(
    .DIV_W(5)
  ) u_prescaler (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .pin_in(pin_in),
    .divider_in(ctl1_r.event_divider),
    .level_out(level)
  );

  // previous divided level for edge detection
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_d_r <= 1'b0;
    end else if (ce_in) begin
      level_d_r <= level;
    end
  end

  // ************************************************************
  // wishbone slave: one wait state, ack for one cycle
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else if (ce_in) begin
      ack_r <= bus_go;
    end
  end

  // read mux, unmapped and reserved bits read zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce_in && bus_go) begin
      unique case (widx)
        cpc_pkg::IDX_COUNTER: rdata_r <= counter_r;
        cpc_pkg::IDX_PHASE: rdata_r <= phase_r;
        cpc_pkg::IDX_CAPTURE_REG_ONE: rdata_r <= cap_r[0];
        cpc_pkg::IDX_CAPTURE_REG_TWO: rdata_r <= cap_r[1];
        cpc_pkg::IDX_CAPTURE_REG_THREE: rdata_r <= cap_r[2];
        cpc_pkg::IDX_CAPTURE_REG_FOUR: rdata_r <= cap_r[3];
        cpc_pkg::IDX_CTL1: rdata_r <= {16'h0000, ctl1_r};
        cpc_pkg::IDX_CTL2: rdata_r <= {16'h0000, ctl2_r};
        cpc_pkg::IDX_INTEN: rdata_r <= {16'h0000, inten_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control registers; action bits never stored
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl1_r <= cpc_pkg::CTL1_RESET;
      ctl2_r <= cpc_pkg::CTL2_RESET;
      inten_r <= cpc_pkg::INTEN_RESET;
    end else if (ce_in && wr) begin
      if (widx == cpc_pkg::IDX_CTL1) begin
        ctl1_r <= 16'(lane_merge({16'h0000, ctl1_r}, wb_dat_in,
            wb_sel_in)); // short register keeps the low half
      end
      if (widx == cpc_pkg::IDX_CTL2) begin
        ctl2_r <= 16'(lane_merge({16'h0000, ctl2_r}, wb_dat_in,
            wb_sel_in));
        ctl2_r.reserved <= '0;
        ctl2_r.soft_sync_force <= 1'b0;
        ctl2_r.oneshot_rearm <= 1'b0;
      end
      if (widx == cpc_pkg::IDX_INTEN) begin
        inten_r <= 16'(lane_merge({16'h0000, inten_r}, wb_dat_in,
            wb_sel_in)) & cpc_pkg::INTEN_MASK;
      end
    end
  end

  // phase offset register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r <= '0;
    end else if (ce_in && wr && widx == cpc_pkg::IDX_PHASE) begin
      phase_r <= lane_merge(phase_r, wb_dat_in, wb_sel_in);
    end
  end

  // ************************************************************
  // time stamp counter
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      counter_r <= '0;
    end else if (ce_in) begin
      if (wr && widx == cpc_pkg::IDX_COUNTER) begin
        counter_r <= lane_merge(counter_r, wb_dat_in, wb_sel_in);
      end else if (sync_load) begin
        counter_r <= phase_r;
      end else if (cap_fire && clear_of(ctl1_r.clear_edge, index_r)) begin
        counter_r <= '0; // stamp taken this edge
      end else if (period_match) begin
        counter_r <= '0; // period clear only in pwm mode
      end else if (!halted) begin
        counter_r <= counter_r + 1'b1;
      end
    end
  end

  // ************************************************************
  // event index and arming
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      index_r <= 2'h0;
      armed_r <= 1'b1;
    end else if (ce_in) begin
      if (rearm) begin
        index_r <= 2'h0;
        armed_r <= 1'b1;
      end else if (cap_fire) begin
        if (index_r == ctl2_r.sequence_limit) begin
          index_r <= 2'h0;
          armed_r <= ~ctl2_r.sequence_mode_select;
        end else begin
          index_r <= index_r + 1'b1;
        end
      end
    end
  end

  // capture registers: stamps, shadow loads and bus writes
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 4; i++) begin
        cap_r[i] <= '0;
      end
    end else if (ce_in) begin
      if (cap_fire && ctl1_r.capture_load_enable) begin
        cap_r[index_r] <= counter_r;
      end
      if (period_match) begin
        cap_r[0] <= cap_r[2]; // shadow period
        cap_r[1] <= cap_r[3]; // shadow compare
      end
      if (wr) begin
        unique case (widx)
          cpc_pkg::IDX_CAPTURE_REG_ONE: begin
            cap_r[0] <= lane_merge(cap_r[0], wb_dat_in, wb_sel_in);
            if (pwm_mode) begin // immediate mode mirror
              cap_r[2] <= lane_merge(cap_r[0], wb_dat_in, wb_sel_in);
            end
          end
          cpc_pkg::IDX_CAPTURE_REG_TWO: begin
            cap_r[1] <= lane_merge(cap_r[1], wb_dat_in, wb_sel_in);
            if (pwm_mode) begin
              cap_r[3] <= lane_merge(cap_r[1], wb_dat_in, wb_sel_in);
            end
          end
          cpc_pkg::IDX_CAPTURE_REG_THREE: begin
            cap_r[2] <= lane_merge(cap_r[2], wb_dat_in, wb_sel_in);
          end
          cpc_pkg::IDX_CAPTURE_REG_FOUR: begin
            cap_r[3] <= lane_merge(cap_r[3], wb_dat_in, wb_sel_in);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // pwm output, sync chain and events
  // ************************************************************
  // high while below compare, inverted when active low
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_r <= 1'b0;
    end else if (ce_in) begin
      pwm_r <= (counter_r < cap_r[1]) ^ ctl2_r.pwm_output_polarity;
    end
  end

  // sync output source select, period accepted in any mode
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_out_r <= 1'b0;
    end else if (ce_in) begin
      unique case (ctl2_r.sync_out_select)
        cpc_pkg::SYNC_OUT_PASS: sync_out_r <= sync_input_in | soft_sync;
        cpc_pkg::SYNC_OUT_PERIOD:
          sync_out_r <= counter_r == cap_r[0];
        default: sync_out_r <= 1'b0;
      endcase
    end
  end

  // event pulses always reported; enables only gate the request
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      event_r <= 8'h00;
      int_r <= 1'b0;
    end else if (ce_in) begin
      event_r <= 8'h00;
      event_r[cpc_pkg::EVT_CAP_BASE + index_r] <= cap_fire;
      event_r[cpc_pkg::EVT_OVF] <= overflow;
      event_r[cpc_pkg::EVT_PRD] <= period_match;
      event_r[cpc_pkg::EVT_CMP] <= compare_match;
      int_r <= |(inten_r[7:0] & { compare_match, period_match,
          overflow,
          cap_fire & (index_r == 2'h3), cap_fire & (index_r == 2'h2),
          cap_fire & (index_r == 2'h1), cap_fire & (index_r == 2'h0),
          1'b0});
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdata_r;
  assign pin_out = pwm_r;
  assign pin_oe_out = pwm_mode;
  assign sync_output_out = sync_out_r;
  assign event_out = event_r;
  assign int_req_out = int_r;

endmodule : cpc_top
`default_nettype wire

/* File: cpc_pkg.sv */
// shared constants, register map and field layouts of the capture/pwm unit
// assumes a 32-bit classic wishbone slave and one 100 MHz clock
package cpc_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_COUNTER = 8'h00; // time_stamp_counter
  localparam logic [7:0] IDX_PHASE = 8'h04; // phase_offset_value
  localparam logic [7:0] IDX_CAPTURE_REG_ONE = 8'h08; // capture_reg_one
  localparam logic [7:0] IDX_CAPTURE_REG_TWO = 8'h0C; // capture_reg_two
  localparam logic [7:0] IDX_CAPTURE_REG_THREE = 8'h10; // capture_reg_three
  localparam logic [7:0] IDX_CAPTURE_REG_FOUR = 8'h14; // capture_reg_four
  localparam logic [7:0] IDX_CTL1 = 8'h28; // capture_control_one
  localparam logic [7:0] IDX_CTL2 = 8'h2A; // capture_control_two
  localparam logic [7:0] IDX_INTEN = 8'h2C; // interrupt_enable
  localparam int ADR_LSB = 2; // word aligned, index sits above bit 1

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  // capture_control_one, bit 15 down to 0
  typedef struct packed {
    logic [1:0] emu_halt_mode; // debug suspend behaviour
    logic [4:0] event_divider; // pin event prescale
    logic capture_load_enable; // allow time stamps into capture regs
    logic [7:0] clear_edge; // {clr4,edge4,...,clr1,edge1}
  } cpc_ctl1_s;

  // capture_control_two, bit 15 down to 0
  typedef struct packed {
    logic [4:0] reserved; // reads zero
    logic pwm_output_polarity; // 1 = active low
    logic capture_or_pwm_select; // 1 = auxiliary_pwm_mode
    logic soft_sync_force; // self clearing, reads zero
    logic [1:0] sync_out_select; // sync_output source
    logic sync_in_enable; // phase load on sync_input
    logic counter_run_control; // 1 = counter runs
    logic oneshot_rearm; // self clearing, reads zero
    logic [1:0] sequence_limit; // stop or wrap after event n+1
    logic sequence_mode_select; // 1 = one-shot
  } cpc_ctl2_s;

  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] CTL2_RESET = 16'h0006; // limit = event four
  localparam logic [15:0] INTEN_RESET = 16'h0000;
  localparam logic [15:0] INTEN_MASK = 16'h00FE; // bit 0 and 15-8 reserved

  // emulation halt field values
  localparam logic [1:0] EMU_STOP_NOW = 2'h0;
  localparam logic [1:0] EMU_RUN_TO_ZERO = 2'h1;

  // sync-out select values
  localparam logic [1:0] SYNC_OUT_PASS = 2'h0;
  localparam logic [1:0] SYNC_OUT_PERIOD = 2'h1;

  // event / enable bit positions
  localparam int EVT_CAP_BASE = 1; // capture events one..four at 1..4
  localparam int EVT_OVF = 5; // counter_overflow_event
  localparam int EVT_PRD = 6; // period_match_event
  localparam int EVT_CMP = 7; // compare_match_event

  localparam logic [31:0] COUNT_ALL_ONES = 32'hFFFF_FFFF;

endpackage : cpc_pkg

/* File: cpc_prescaler.sv */
// event divider on the synchronous pin input
// assumes the pin is already synchronous to sys_clk_in
`timescale 1ns/1ps
`default_nettype none
module cpc_prescaler #(
  parameter int DIV_W = 5 // width of the divider field
) (
  input wire logic sys_clk_in, // functional clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic ce_in, // clock enable, freezes state when low
  input wire logic pin_in, // raw pin level
  input wire logic [DIV_W-1:0] divider_in, // 0 bypass, n divides by 2n
  output logic level_out // divided pin level
);

  // ************************************************************
  // divider state
  // ************************************************************
  logic pin_d_r; // previous pin level
  logic [DIV_W-1:0] count_r; // rising edges since last toggle
  logic level_r; // toggling divided level
  logic rise; // rising pin edge

  assign rise = pin_in & ~pin_d_r;

  // previous pin sample for edge detection
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_d_r <= 1'b0;
    end else if (ce_in) begin
      pin_d_r <= pin_in;
    end
  end

  // toggle every n rising edges: period of 2n input periods
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_r <= '0;
      level_r <= 1'b0;
    end else if (ce_in) begin
      if (divider_in == '0) begin // bypass, follow pin
        count_r <= '0;
        level_r <= pin_in;
      end else if (rise) begin
        if (count_r == divider_in - 1'b1) begin
          count_r <= '0;
          level_r <= ~level_r;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

  assign level_out = level_r;

endmodule : cpc_prescaler
`default_nettype wire

/* File: cpc_sva.sv */
// assertion checker for the capture/pwm unit, bound to cpc_top
// assumes one clock, async low reset, ce_in held high by the bench
`timescale 1ns/1ps
`default_nettype none
module cpc_sva (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic sync_input_in,
  input wire logic sync_output_out,
  input wire logic pin_oe_out,
  input wire logic [7:0] event_out,
  input wire logic int_req_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] inten_r; // shadow of the enable register
  logic [1:0] osel_r; // shadow of sync_out_select
  wire take = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in;
  // ******************************
  // shadows follow accepted writes
  // ******************************
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      inten_r <= 8'h00;
      osel_r <= 2'h0;
    end else if (take && wb_sel_in[0]) begin
      if (wb_adr_in == 10'h0B0) inten_r <= wb_dat_in[7:0] & 8'hFE;
      if (wb_adr_in == 10'h0A8) osel_r <= wb_dat_in[7:6];
    end
  end
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ctl2_wr;
    wb_ack_out && wb_we_in && wb_adr_in == 10'h0A8 && wb_sel_in[1];
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in >= 10'h0A0 |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper half of short register not zero");
  a_mode_pin: assert property (s_ctl2_wr |=>
    pin_oe_out == $past(wb_dat_in[9]))
    else $error("pin direction does not follow mode");
  a_sync_pass: assert property (osel_r == 2'h0 && sync_input_in
    |=> sync_output_out)
    else $error("sync input not passed through");
  a_sync_off: assert property ($past(osel_r[1]) |-> !sync_output_out)
    else $error("sync output while disabled");
  a_int_gate: assert property (
    int_req_out == |(event_out & $past(inten_r)))
    else $error("interrupt request not gated by enables");
  a_pwm_no_cap: assert property (
    pin_oe_out && $past(pin_oe_out, 3) |-> event_out[4:1] == 4'h0)
    else $error("capture event in pwm mode");
endmodule : cpc_sva
bind cpc_top cpc_sva cpc_sva_inst (.sys_clk_in, .rst_b_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
  .wb_ack_out, .sync_input_in, .sync_output_out, .pin_oe_out, .event_out,
  .int_req_out);
`default_nettype wire

/* File: cpc_pin_model.sv */
// partner: event source and pwm load on the shared pin
// assumes the same clock as the unit
`timescale 1ns/1ps
`default_nettype none
module cpc_pin_model (
  input wire logic sys_clk_in, // shared clock
  input wire logic source_in, // level the event source wants
  input wire logic pwm_in, // level the unit drives
  input wire logic oe_in, // unit drives the pin
  input wire logic clear_in, // restart the high-time count
  output logic pin_wire_out, // resolved pin level
  output logic [7:0] high_count_out // cycles seen high at the load
);
  // source lets go while the unit drives, so no contention
  assign pin_wire_out = oe_in ? pwm_in : source_in;
  // load integrates the high time of the output
  always_ff @(posedge sys_clk_in) begin
    if (clear_in) begin
      high_count_out <= 8'h00;
    end else if (oe_in && pin_wire_out) begin
      high_count_out <= high_count_out + 8'h01;
    end
  end
endmodule : cpc_pin_model
`default_nettype wire

/* File: cpc_top_bench.sv */
// self-checking bench of the capture/pwm unit
// assumes cpc_top, cpc_pin_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cpc_top_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc, stb, we, emu, src, syn, clr, ack, pin_o, oe, sync_o, irq, lv;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q, x, y;
  logic [7:0] evt, hi_cnt;
  int failures = 0;
  int n_tests = 0;
  int n_ev = 0;
  always #5 sys_clk = ~sys_clk;
  cpc_top cpc_top_inst (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .ce_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .emu_suspend_in(emu), .pin_in(lv), .pin_out(pin_o), .pin_oe_out(oe),
    .sync_input_in(syn), .sync_output_out(sync_o), .event_out(evt),
    .int_req_out(irq));
  cpc_pin_model cpc_pin_model_inst (.sys_clk_in(sys_clk), .source_in(src),
    .pwm_in(pin_o), .oe_in(oe), .clear_in(clr), .pin_wire_out(lv),
    .high_count_out(hi_cnt));
  // count capture event pulses
  always @(posedge sys_clk) if (evt[4:1] !== 4'h0) n_ev++;
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    q = rdat;
    if (n == 50) begin
      failures++;
      stop_test();
    end
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk);
  endtask : wb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic pulse(input logic s);
    if (s) syn <= 1'b1;
    else src <= 1'b1;
    repeat (6) @(posedge sys_clk);
    {syn, src} <= 2'b00;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  // high cycles of the pwm load over twenty cycles
  task automatic measure(input logic [31:0] e);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (21) @(posedge sys_clk);
    chk({24'h0, hi_cnt}, e);
  endtask : measure
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    {cyc, stb, we, emu, src, syn, clr} = 7'h00;
    {adr, sel, dat} = 46'h0;
    void'($urandom(7672));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(10'h0A0, 32'h0);
    rd(10'h0A8, 32'h6);
    wr(10'h3F0, $urandom);
    rd(10'h3F0, 32'h0);
    x = $urandom;
    wr(10'h0B0, x);
    rd(10'h0B0, x & 32'hFE);
    wr(10'h0A8, 32'h010C);
    rd(10'h0A8, 32'h0004);
    x = $urandom;
    y = $urandom;
    wr(10'h000, x);
    wr(10'h0A0, 32'h0106); // loads on, clear on one, event two falls
    wr(10'h0A8, 32'h000A); // continuous, wrap after two, stopped
    n_ev = 0;
    pulse(1'b0);
    rd(10'h020, x);
    rd(10'h030, 32'h0);
    rd(10'h000, 32'h0);
    wr(10'h000, y);
    pulse(1'b0);
    rd(10'h020, y);
    rd(10'h040, 32'h0);
    chk(n_ev, 4);
    wr(10'h000, x);
    wr(10'h0A8, 32'h0009); // one-shot, stop after one, rearm
    pulse(1'b0);
    rd(10'h020, x);
    wr(10'h000, y);
    pulse(1'b0);
    rd(10'h020, x);
    wr(10'h0A0, 32'h0006); // loads off
    wr(10'h0A8, 32'h0009);
    pulse(1'b0);
    rd(10'h020, x);
    wr(10'h0A0, 32'h0106);
    wr(10'h000, y);
    wr(10'h0A8, 32'h0009);
    pulse(1'b0);
    rd(10'h020, y);
    wr(10'h0A0, 32'h0300); // divide by two
    wr(10'h0A8, 32'h000E);
    n_ev = 0;
    repeat (4) pulse(1'b0);
    chk(n_ev, 2);
    wr(10'h0A8, 32'h0200); // stop before reconfiguring
    wr(10'h020, 32'h9);
    wr(10'h030, 32'h3);
    wr(10'h000, 32'h0);
    wr(10'h0A8, 32'h0210);
    measure(6);
    wr(10'h0A8, 32'h0610);
    measure(14);
    x = $urandom;
    wr(10'h010, x);
    wr(10'h0A8, 32'h0000);
    wr(10'h000, 32'h0);
    wr(10'h0A8, 32'h0100);
    rd(10'h000, x);
    wr(10'h000, 32'h0);
    wr(10'h0A8, 32'h0020);
    pulse(1'b1);
    rd(10'h000, x);
    wr(10'h000, 32'h0);
    wr(10'h0A8, 32'h0080);
    pulse(1'b1);
    rd(10'h000, 32'h0);
    wr(10'h0A8, 32'h0040);
    rd(10'h0A8, 32'h0040);
    wr(10'h0A0, 32'h0000);
    wr(10'h0A8, 32'h0010);
    emu <= 1'b1;
    wr(10'h000, y);
    rd(10'h000, y);
    wr(10'h0A0, 32'h4000); // suspend runs counter to zero
    wr(10'h000, 32'hFFFF_FFF0);
    repeat (30) @(posedge sys_clk);
    rd(10'h000, 32'h0);
    wr(10'h0A0, 32'h8000); // suspend ignored, free run
    wr(10'h000, y);
    // two edges pass between the write and the read capture
    rd(10'h000, y + 32'h2);
    emu <= 1'b0;
    stop_test();
  end
endmodule : cpc_top_bench
`default_nettype wire
